// File: core/tlc_channel_select.v
// Local design decision: the plain strobed port.
`timescale 1ns/10ps
`include "tlc_regs.vh"

module tlc_channel_select #(
   parameter [31:0] CH_MAX      = 32'h0000FFFF,
   parameter [15:0] CH_LO_RESET = 16'h0001
) (
   input  wire        i_clk_sys,        // System clock, 250 MHz
   input  wire        i_rst_b,          // Async reset, active low
   input  wire [7:0]  i_addr,           // Register number
   input  wire [15:0] i_wdata,          // Write data
   input  wire        i_wr,             // Write strobe
   input  wire        i_rd,             // Read strobe
   output reg  [15:0] o_rdata,          // Response data
   output reg         o_resp_valid,     // Response strobe
   output reg  [1:0]  o_resp_status,    // Response status field
   output reg  [3:0]  o_resp_err,       // Error condition field
   output reg         o_tune_start,     // Start tuning pulse
   output reg  [63:0] o_tune_freq_mhz,  // Target frequency, MHz
   output reg  [31:0] o_channel,        // Committed channel
   input  wire        i_tune_done,      // Tuning finished ok
   input  wire        i_tune_fail,      // Tuning failed
   output reg         o_srq,            // Service request level
   output reg         o_irq             // Interrupt level
);

   ////////////////////////////////////////////////////////////////////
   // Sign extension helper
   function [63:0] tlc_sx16;
      input [15:0] v;
      begin
         tlc_sx16 = {{48{v[15]}}, v};
      end
   endfunction

   // Zero extension helper
   function [63:0] tlc_zx16;
      input [15:0] v;
      begin
         tlc_zx16 = {48'h0, v};
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Storage
   reg [15:0] ch_lo;
   reg [15:0] ch_hi;
   reg [15:0] ch_hi_new;
   reg [15:0] grid;
   reg [15:0] fine_grid_spacing;
   reg [15:0] first_freq_thz_part;
   reg [15:0] first_freq_ghz_part;
   reg [15:0] first_freq_mhz_part;
   reg [15:0] fine_tune_frequency;
   reg [15:0] fatal_status_reg;
   reg [15:0] warning_status_reg;
   reg [15:0] srq_trig;
   reg [2:0]  irq_stat;
   reg [2:0]  irq_mask;
   reg        pending;
   reg [3:0]  last_err;

   ////////////////////////////////////////////////////////////////////
   // Requested channel and its frequency
   wire [31:0] req_ch = {ch_hi_new, i_wdata};                 // R1 R2 R4
   wire        ch_bad = (req_ch == 32'h0) || (req_ch > CH_MAX); // R13
   wire [63:0] ch_m1  = {32'h0, req_ch} - 64'd1;

   // Grid spacing in MHz: coarse in 100 MHz, fine in 1 MHz
   wire [63:0] grid_mhz = tlc_sx16(grid) * `TLC_MHZ_PER_DGHZ
                        + tlc_sx16(fine_grid_spacing);                    // R5

   // First channel frequency in MHz
   wire [63:0] fcf_mhz = tlc_zx16(first_freq_thz_part) * `TLC_MHZ_PER_THZ
                       + tlc_zx16(first_freq_ghz_part) * `TLC_MHZ_PER_DGHZ
                       + tlc_zx16(first_freq_mhz_part);                      // R5

   // Two's complement product keeps negative grids correct
   wire [63:0] freq_mhz = ch_m1 * grid_mhz + fcf_mhz
                        + tlc_sx16(fine_tune_frequency);                      // R5

   ////////////////////////////////////////////////////////////////////
   // Decoded events
   wire wr_lo   = i_wr && (i_addr == `TLC_OFS_CH_LO);
   wire wr_hi   = i_wr && (i_addr == `TLC_OFS_CH_HI);
   wire lo_busy = wr_lo && pending;
   wire lo_rng  = wr_lo && !pending && ch_bad;
   wire lo_ok   = wr_lo && !pending && !ch_bad;
   wire rd_stat = i_rd && (i_addr == `TLC_OFS_IRQ_STAT);
   wire fail_ev = pending && i_tune_fail;
   wire done_ev = pending && i_tune_done && !i_tune_fail;

   ////////////////////////////////////////////////////////////////////
   // Response formation
   reg [15:0] next_rdata;
   reg [1:0]  next_status;
   reg [3:0]  next_err;
   reg        next_valid;

   // Reads return current committed values only
   always @* begin
      next_rdata  = 16'h0000;
      next_status = `TLC_ST_OK;
      next_err    = `TLC_ER_OK;
      next_valid  = i_wr || i_rd;
      if (i_rd) begin
         case (i_addr)
            `TLC_OFS_NOP: begin
               next_rdata = {7'h0, pending, 4'h0, last_err}; // R14
            end
            `TLC_OFS_FATAL:    next_rdata = fatal_status_reg;
            `TLC_OFS_WARN:     next_rdata = warning_status_reg;
            `TLC_OFS_SRQT:     next_rdata = srq_trig;
            `TLC_OFS_CH_LO:    next_rdata = ch_lo;
            `TLC_OFS_CH_HI:    next_rdata = ch_hi;        // R8
            `TLC_OFS_GRID:     next_rdata = grid;
            `TLC_OFS_FINE_GRID_SPACING:    next_rdata = fine_grid_spacing;
            `TLC_OFS_FIRST_FREQ_THZ_PART:     next_rdata = first_freq_thz_part;
            `TLC_OFS_FIRST_FREQ_GHZ_PART:     next_rdata = first_freq_ghz_part;
            `TLC_OFS_FIRST_FREQ_MHZ_PART:     next_rdata = first_freq_mhz_part;
            `TLC_OFS_FTF:      next_rdata = fine_tune_frequency;
            `TLC_OFS_IRQ_STAT: next_rdata = {13'h0, irq_stat};
            `TLC_OFS_IRQ_MASK: next_rdata = {13'h0, irq_mask};
            default: begin
               next_status = `TLC_ST_XE;                  // R10
               next_err    = `TLC_ER_CII;
            end
         endcase
      end else if (i_wr) begin
         case (i_addr)
            `TLC_OFS_CH_LO: begin
               if (lo_busy) begin
                  next_status = `TLC_ST_XE;               // R10
                  next_err    = `TLC_ER_CIP;
               end else if (lo_rng) begin
                  next_status = `TLC_ST_XE;               // R10 R13
                  next_err    = `TLC_ER_RVE;
               end else begin
                  next_status = `TLC_ST_CP;               // R9
                  next_rdata  = `TLC_PEND_ID;
               end
            end
            `TLC_OFS_NOP,
            `TLC_OFS_IRQ_STAT: begin
               next_status = `TLC_ST_XE;                  // R10
               next_err    = `TLC_ER_RNW;
            end
            `TLC_OFS_FATAL, `TLC_OFS_WARN, `TLC_OFS_SRQT,
            `TLC_OFS_CH_HI, `TLC_OFS_GRID, `TLC_OFS_FINE_GRID_SPACING,
            `TLC_OFS_FIRST_FREQ_THZ_PART, `TLC_OFS_FIRST_FREQ_GHZ_PART, `TLC_OFS_FIRST_FREQ_MHZ_PART,
            `TLC_OFS_FTF, `TLC_OFS_IRQ_MASK: begin
               next_rdata = i_wdata;                      // R9
            end
            default: begin
               next_status = `TLC_ST_XE;                  // R10
               next_err    = `TLC_ER_CII;
            end
         endcase
      end
   end

   // Response registers, one cycle after the strobe
   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_rdata       <= 16'h0000;
         o_resp_valid  <= 1'b0;
         o_resp_status <= `TLC_ST_OK;
         o_resp_err    <= `TLC_ER_OK;
      end else begin
         o_rdata       <= next_rdata;
         o_resp_valid  <= next_valid;
         o_resp_status <= next_status;
         o_resp_err    <= next_err;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Channel pair, staging and tune launch
   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ch_lo           <= CH_LO_RESET;
         ch_hi           <= `TLC_RST_CH_HI;               // R3
         ch_hi_new       <= `TLC_RST_CH_HI;
         o_tune_start    <= 1'b0;
         o_tune_freq_mhz <= 64'h0;
         o_channel       <= 32'h0;
         pending         <= 1'b0;
      end else begin
         o_tune_start <= lo_ok;                           // R6
         o_channel    <= {ch_hi, ch_lo};                  // R1
         // Staged only; reads keep the old upper word
         if (wr_hi) begin
            ch_hi_new <= i_wdata;                         // R8
         end
         // Upper word sent first is committed here
         if (lo_ok) begin
            ch_lo           <= i_wdata;                   // R6 R7
            ch_hi           <= ch_hi_new;                 // R8
            o_tune_freq_mhz <= freq_mhz;                  // R5
         end
         // New operation wins over a finish in the same cycle
         if (lo_ok) begin
            pending <= 1'b1;                              // R9
         end else if (done_ev || fail_ev) begin
            pending <= 1'b0;                              // R14
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Grid, frequency and fine-tune settings
   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         grid  <= `TLC_RST_ZERO;
         fine_grid_spacing <= `TLC_RST_ZERO;
         first_freq_thz_part  <= `TLC_RST_ZERO;
         first_freq_ghz_part  <= `TLC_RST_ZERO;
         first_freq_mhz_part  <= `TLC_RST_ZERO;
         fine_tune_frequency   <= `TLC_RST_ZERO;
      end else if (i_wr) begin
         case (i_addr)
            `TLC_OFS_GRID:  grid  <= i_wdata;
            `TLC_OFS_FINE_GRID_SPACING: fine_grid_spacing <= i_wdata;
            `TLC_OFS_FIRST_FREQ_THZ_PART:  first_freq_thz_part  <= i_wdata;
            `TLC_OFS_FIRST_FREQ_GHZ_PART:  first_freq_ghz_part  <= i_wdata;
            `TLC_OFS_FIRST_FREQ_MHZ_PART:  first_freq_mhz_part  <= i_wdata;
            `TLC_OFS_FTF:   fine_tune_frequency   <= i_wdata;
            default: begin
               grid <= grid;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Status latches: write one to clear, a new failure wins
   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         fatal_status_reg   <= `TLC_RST_ZERO;
         warning_status_reg <= `TLC_RST_ZERO;
         srq_trig           <= `TLC_RST_SRQT;             // R12
         last_err           <= `TLC_ER_OK;
      end else begin
         if (i_wr && i_addr == `TLC_OFS_FATAL) begin
            fatal_status_reg <= fatal_status_reg & ~i_wdata;
         end
         if (i_wr && i_addr == `TLC_OFS_WARN) begin
            warning_status_reg <= warning_status_reg & ~i_wdata;
         end
         if (fail_ev) begin
            fatal_status_reg[`TLC_XEL_BIT]   <= 1'b1;     // R11
            warning_status_reg[`TLC_XEL_BIT] <= 1'b1;     // R11
         end
         if (i_wr && i_addr == `TLC_OFS_SRQT) begin
            srq_trig <= i_wdata;
         end
         // Last outcome visible in the no-operation register
         if (fail_ev) begin
            last_err <= `TLC_ER_EXF;
         end else if (next_valid && next_err != `TLC_ER_OK) begin
            last_err <= next_err;
         end else if (lo_ok) begin
            last_err <= `TLC_ER_OK;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Service request: level while an enabled latch is set
   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_srq <= 1'b0;
      end else begin
         o_srq <= |((fatal_status_reg | warning_status_reg)
                    & srq_trig);                          // R12
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Interrupts: sticky, cleared by reading, set beats clear
   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         irq_stat <= 3'h0;
         irq_mask <= 3'h0;
         o_irq    <= 1'b0;
      end else begin
         irq_stat <= (rd_stat ? 3'h0 : irq_stat)
                   | {(next_valid && next_status == `TLC_ST_XE),
                      fail_ev, done_ev};
         if (i_wr && i_addr == `TLC_OFS_IRQ_MASK) begin
            irq_mask <= i_wdata[2:0];
         end
         // One cycle behind the status bits to stay a flop output
         o_irq <= |(irq_stat & irq_mask);
      end
   end

endmodule

// File: shared/tlc_regs.vh
// Operation
// R1 - The upper and lower channel words together form one unsigned 32-bit channel number.
// R2 - The lower word gives bits 15:0 and the upper word bits 31:16 of the channel.
// R3 - The upper channel word resets to zero and is kept together with the lower word.
// R4 - Writing only the lower word selects a 16-bit channel correctly; the code uses the staged upper word, so only while it is zero.
// R5 - Target frequency is (channel-1) times grid spacing plus first frequency plus fine tune.
// R6 - Only a lower-word write starts tuning; an upper-word write never does.
// R7 - The host writes the upper word first and the lower word second.
// R8 - A new upper word stays staged and reads return the old value until a lower write commits it.
// R9 - An upper write answers OK with its data; an accepted lower write answers pending with an ID.
// R10 - A failed access answers execution error with zero data and an error code.
// R11 - A tuning failure sets the error latch bit in the fatal and warning status registers.
// R12 - A tuning failure raises service request when the trigger mask enables the latch bit.
// R13 - Channel zero or beyond the supported range is refused with an error, channel unchanged.
// R14 - The host polls the pending bit until it clears and then reads status.
`ifndef TLC_REGS_VH
`define TLC_REGS_VH

// Register offsets
`define TLC_OFS_NOP       8'h00
`define TLC_OFS_FATAL     8'h20
`define TLC_OFS_WARN      8'h21
`define TLC_OFS_SRQT      8'h28
`define TLC_OFS_CH_LO     8'h30
`define TLC_OFS_GRID      8'h34
`define TLC_OFS_FIRST_FREQ_THZ_PART      8'h35
`define TLC_OFS_FIRST_FREQ_GHZ_PART      8'h36
`define TLC_OFS_FTF       8'h62
`define TLC_OFS_CH_HI     8'h65
`define TLC_OFS_FINE_GRID_SPACING     8'h66
`define TLC_OFS_FIRST_FREQ_MHZ_PART      8'h67
`define TLC_OFS_IRQ_STAT  8'h70
`define TLC_OFS_IRQ_MASK  8'h71

// Reset values
`define TLC_RST_CH_HI     16'h0000
`define TLC_RST_SRQT      16'h0080
`define TLC_RST_ZERO      16'h0000

// Field positions
`define TLC_XEL_BIT       7
`define TLC_PEND_BIT      8
`define TLC_IRQ_DONE      0
`define TLC_IRQ_FAIL      1
`define TLC_IRQ_CMDERR    2

// Response status codes
`define TLC_ST_OK         2'h0
`define TLC_ST_XE         2'h1
`define TLC_ST_CP         2'h3

// Error condition codes
`define TLC_ER_OK         4'h0
`define TLC_ER_RNW        4'h1
`define TLC_ER_RVE        4'h2
`define TLC_ER_CIP        4'h3
`define TLC_ER_CII        4'h4
`define TLC_ER_EXF        4'h5
`define TLC_ER_VSE        4'h6

// Pending identifier returned by an accepted lower write
`define TLC_PEND_ID       16'h0100

// Frequency scale factors to MHz
`define TLC_MHZ_PER_THZ   64'd1000000
`define TLC_MHZ_PER_DGHZ  64'd100

`endif

// File: tb/tlc_channel_select_monitor.sv
`timescale 1ns/10ps
`include "tlc_regs.vh"
module tlc_channel_select_monitor (
   input wire        i_clk_sys,      // Clock
   input wire        i_rst_b,        // Reset, active low
   input wire [7:0]  i_addr,         // Register number
   input wire [15:0] i_wdata,        // Write data
   input wire        i_wr,           // Write strobe
   input wire        i_rd,           // Read strobe
   input wire [15:0] o_rdata,        // Response data
   input wire        o_resp_valid,   // Response strobe
   input wire [1:0]  o_resp_status,  // Status field
   input wire [3:0]  o_resp_err,     // Error field
   input wire        o_tune_start,   // Tuning start
   input wire [31:0] o_channel,      // Committed channel
   input wire        i_tune_fail,    // Tuning failure
   input wire        o_srq           // Service request
);
default clocking cb @(posedge i_clk_sys); endclocking
default disable iff (!i_rst_b);
////////////////////////////////////////////////////////////////////////
// Response timing
property p_resp; (i_wr || i_rd) |=> o_resp_valid; endproperty
a_resp: assert property (p_resp) else $error("no response after strobe");
property p_lone; o_resp_valid |-> $past(i_wr || i_rd); endproperty
a_lone: assert property (p_lone) else $error("response without strobe");
// Upper word echoes and never starts tuning
property p_hi_echo;
   (i_wr && i_addr == `TLC_OFS_CH_HI) |=> !o_tune_start && o_resp_status == `TLC_ST_OK && o_rdata == $past(i_wdata);
endproperty
a_hi_echo: assert property (p_hi_echo) else $error("upper write answer wrong");
property p_start_src;
   o_tune_start |-> $past(i_wr) && $past(i_addr) == `TLC_OFS_CH_LO && o_resp_status == `TLC_ST_CP
      && o_rdata == `TLC_PEND_ID;
endproperty
a_start_src: assert property (p_start_src) else $error("tuning start without pending lower write");
property p_xe_zero;
   (o_resp_valid && o_resp_status == `TLC_ST_XE) |-> o_rdata == 16'h0000 && o_resp_err != `TLC_ER_OK;
endproperty
a_xe_zero: assert property (p_xe_zero) else $error("error answer carries data");
// Commit lands one cycle after the start pulse
property p_low_commit; o_tune_start |=> o_channel[15:0] == $past(i_wdata, 2); endproperty
a_low_commit: assert property (p_low_commit) else $error("lower word not committed");
// Guard of two cycles skips the reset load of the channel
property p_hold; ($changed(o_channel) && $past(i_rst_b, 2)) |-> $past(o_tune_start); endproperty
a_hold: assert property (p_hold) else $error("channel changed without accepted write");
property p_srq; $rose(o_srq) |-> $past(i_tune_fail, 2); endproperty
a_srq: assert property (p_srq) else $error("service request without tuning failure");
endmodule
bind tlc_channel_select tlc_channel_select_monitor u_mon (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
   .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
   .o_resp_valid(o_resp_valid), .o_resp_status(o_resp_status), .o_resp_err(o_resp_err),
   .o_tune_start(o_tune_start), .o_channel(o_channel), .i_tune_fail(i_tune_fail), .o_srq(o_srq));

// File: tb/tlc_tune_model.sv
`timescale 1ns/10ps
module tlc_tune_model #(
   parameter int DELAY = 20
) (
   input  wire  i_clk_sys,    // Clock
   input  wire  i_rst_b,      // Reset, active low
   input  wire  i_start,      // Tuning start pulse
   input  wire  i_fail_mode,  // Answer with failure
   output logic o_done,       // Success pulse
   output logic o_fail        // Failure pulse
);
logic [7:0] cnt;
logic       busy;
// Slow engine so that a second write meets a pending operation
always @(posedge i_clk_sys or negedge i_rst_b) begin
   if (!i_rst_b) begin
      cnt <= 8'h00;
      busy <= 1'b0;
      o_done <= 1'b0;
      o_fail <= 1'b0;
   end else begin
      o_done <= busy && cnt == 8'h01 && !i_fail_mode;
      o_fail <= busy && cnt == 8'h01 && i_fail_mode;
      if (i_start) begin
         busy <= 1'b1;
         cnt <= DELAY[7:0];
      end else if (busy) begin
         cnt <= cnt - 8'h01;
         busy <= cnt != 8'h01;
      end
   end
end
endmodule

// File: tb/tunable_laser_channel_select_bench.sv
`timescale 1ns/10ps
`include "tlc_regs.vh"
module tunable_laser_channel_select_bench;
logic        i_clk_sys = 0, i_rst_b = 0, i_wr = 0, i_rd = 0, fail_mode = 0;
logic [7:0]  i_addr = 8'h00;
logic [15:0] i_wdata = 16'h0000, q;
wire  [15:0] o_rdata;
wire  [1:0]  o_resp_status;
wire  [3:0]  o_resp_err;
wire  [63:0] o_tune_freq_mhz;
wire  [31:0] o_channel;
wire         o_resp_valid, o_tune_start, i_tune_done, i_tune_fail, o_srq, o_irq;
int          failures = 0, n_checks = 0;
localparam logic [63:0] GRID_MHZ = 64'h1F4 * 64'h64;
localparam logic [63:0] FCF_MHZ = 64'hC4 * 64'hF4240 + 64'hBB8 * 64'h64;
initial forever #2 i_clk_sys = ~i_clk_sys;
// Wide channel limit so the 32-bit example fits
tlc_channel_select #(.CH_MAX(32'h00FFFFFF)) dut (.i_clk_sys, .i_rst_b, .i_addr, .i_wdata, .i_wr, .i_rd,
   .o_rdata, .o_resp_valid, .o_resp_status, .o_resp_err, .o_tune_start, .o_tune_freq_mhz, .o_channel,
   .i_tune_done, .i_tune_fail, .o_srq, .o_irq);
tlc_tune_model #(.DELAY(20)) u_eng (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_start(o_tune_start),
   .i_fail_mode(fail_mode), .o_done(i_tune_done), .o_fail(i_tune_fail));
////////////////////////////////////////////////////////////////////////
task check(input logic [63:0] seen, input logic [63:0] exp);
   n_checks++;
   if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
   end
endtask
// One strobe, answer sampled in the single cycle it stands
task acc(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [1:0] es,
         input logic [3:0] ee, input logic [15:0] ed);
   @(posedge i_clk_sys);
   i_wr <= w;
   i_rd <= !w;
   i_addr <= a;
   i_wdata <= d;
   @(posedge i_clk_sys);
   i_wr <= 1'b0;
   i_rd <= 1'b0;
   #1 q = o_rdata;
   check(o_resp_valid, 1);
   check(o_resp_status, es);
   check(o_resp_err, ee);
   check(q, ed);
endtask
// Poll the pending bit under a bounded count; word is pending or final value
task poll(input logic [15:0] pv, input logic [15:0] dv);
   int i;
   for (i = 0; i < 60; i++) begin
      @(posedge i_clk_sys);
      i_rd <= 1'b1;
      i_addr <= `TLC_OFS_NOP;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      #1 q = o_rdata;
      check(o_resp_valid, 1);
      check(o_resp_status, `TLC_ST_OK);
      check(q == pv || q == dv, 1);
      if (q[`TLC_PEND_BIT] === 1'b0) break;
   end
   check(q, dv);
endtask
task final_report;
   $display("checks=%0d failures=%0d", n_checks, failures);
   if (failures == 0 && n_checks > 0) $display("Finished cleanly");
   else $display("Finished with errors");
   $finish;
endtask
////////////////////////////////////////////////////////////////////////
initial begin
   #40000;
   failures++;
   final_report;
end
initial begin
   repeat (16) @(posedge i_clk_sys);
   i_rst_b <= 1'b1;
   acc(0, `TLC_OFS_CH_HI, 16'h0000, `TLC_ST_OK, `TLC_ER_OK, 16'h0000);
   check(o_channel, 32'h00000001);
   acc(0, `TLC_OFS_SRQT, 16'h0000, `TLC_ST_OK, `TLC_ER_OK, 16'h0080);
   acc(1, `TLC_OFS_GRID, 16'h01F4, `TLC_ST_OK, `TLC_ER_OK, 16'h01F4);
   acc(1, `TLC_OFS_FIRST_FREQ_THZ_PART, 16'h00C4, `TLC_ST_OK, `TLC_ER_OK, 16'h00C4);
   acc(1, `TLC_OFS_FIRST_FREQ_GHZ_PART, 16'h0BB8, `TLC_ST_OK, `TLC_ER_OK, 16'h0BB8);
   acc(1, `TLC_OFS_CH_LO, 16'h00AA, `TLC_ST_CP, `TLC_ER_OK, `TLC_PEND_ID);
   check(o_tune_start, 1);
   check(o_tune_freq_mhz, 64'hA9 * GRID_MHZ + FCF_MHZ);
   poll(16'h0100, 16'h0000);
   acc(1, `TLC_OFS_CH_HI, 16'h000F, `TLC_ST_OK, `TLC_ER_OK, 16'h000F);
   check(o_tune_start, 0);
   acc(0, `TLC_OFS_CH_HI, 16'h0000, `TLC_ST_OK, `TLC_ER_OK, 16'h0000);
   acc(1, `TLC_OFS_CH_LO, 16'h0555, `TLC_ST_CP, `TLC_ER_OK, `TLC_PEND_ID);
   check(o_tune_freq_mhz, 64'hF0554 * GRID_MHZ + FCF_MHZ);
   acc(1, `TLC_OFS_CH_LO, 16'h0556, `TLC_ST_XE, `TLC_ER_CIP, 16'h0000);
   poll(16'h0103, 16'h0003);
   acc(0, `TLC_OFS_CH_HI, 16'h0000, `TLC_ST_OK, `TLC_ER_OK, 16'h000F);
   acc(0, `TLC_OFS_CH_LO, 16'h0000, `TLC_ST_OK, `TLC_ER_OK, 16'h0555);
   check(o_channel, 32'h000F0555);
   // Out of range above the limit, then channel zero
   acc(1, `TLC_OFS_CH_HI, 16'h0100, `TLC_ST_OK, `TLC_ER_OK, 16'h0100);
   acc(1, `TLC_OFS_CH_LO, 16'h0001, `TLC_ST_XE, `TLC_ER_RVE, 16'h0000);
   acc(1, `TLC_OFS_CH_HI, 16'h0000, `TLC_ST_OK, `TLC_ER_OK, 16'h0000);
   acc(1, `TLC_OFS_CH_LO, 16'h0000, `TLC_ST_XE, `TLC_ER_RVE, 16'h0000);
   acc(0, `TLC_OFS_CH_LO, 16'h0000, `TLC_ST_OK, `TLC_ER_OK, 16'h0555);
   check(o_channel, 32'h000F0555);
   acc(1, `TLC_OFS_NOP, 16'h0001, `TLC_ST_XE, `TLC_ER_RNW, 16'h0000);
   acc(0, 8'h7F, 16'h0000, `TLC_ST_XE, `TLC_ER_CII, 16'h0000);
   // Masked events leave the interrupt low; read clears them
   check(o_irq, 0);
   acc(0, `TLC_OFS_IRQ_STAT, 16'h0000, `TLC_ST_OK, `TLC_ER_OK, 16'h0005);
   acc(1, `TLC_OFS_IRQ_MASK, 16'h0002, `TLC_ST_OK, `TLC_ER_OK, 16'h0002);
   fail_mode <= 1'b1;
   acc(1, `TLC_OFS_CH_LO, 16'h0002, `TLC_ST_CP, `TLC_ER_OK, `TLC_PEND_ID);
   poll(16'h0100, 16'h0005);
   acc(0, `TLC_OFS_FATAL, 16'h0000, `TLC_ST_OK, `TLC_ER_OK, 16'h0080);
   acc(0, `TLC_OFS_WARN, 16'h0000, `TLC_ST_OK, `TLC_ER_OK, 16'h0080);
   check(o_srq, 1);
   check(o_irq, 1);
   acc(0, `TLC_OFS_IRQ_STAT, 16'h0000, `TLC_ST_OK, `TLC_ER_OK, 16'h0002);
   @(posedge i_clk_sys);
   #1 check(o_irq, 0);
   final_report;
end
endmodule
